//--- rtl/gpio_bank_pkg.sv
// Constants, modes and carrier types for the programmable I/O port bank
package gpio_bank_pkg;
  localparam int NUM_PORTS = 11;
  localparam int PORT_W = 8;
  localparam int NUM_BITS = NUM_PORTS * PORT_W;
  localparam int GROUP_W = 4;
  localparam int NUM_GROUPS = NUM_BITS / GROUP_W;
  localparam int PORT_SEL_W = 4;
  localparam int MODE_SEL_W = 2;
  // Bit index of the input-only bit shared with the NMI line (port 8, bit 5)
  localparam int SHARED_IDX = 69;
  localparam logic [PORT_SEL_W-1:0] HIGH_SINK_PORT = 4'h7;
  localparam logic [PORT_W-1:0] OPEN_DRAIN_MASK = 8'h03;
  // 81 bidirectional bits: ports 9 and 10 carry five bits, port 8 lacks its shared bit
  localparam logic [NUM_BITS-1:0] BIDIR_MASK = 88'h1F1FDF_FFFFFFFF_FFFFFFFF;
  localparam logic [NUM_BITS-1:0] SHARED_MASK = 88'h000020_00000000_00000000;
  // Pins taken by the external bus in expansion and microprocessor modes
  localparam logic [NUM_BITS-1:0] BUS_PIN_MASK = 88'h000000_0000FFFF_FFFFFFFF;
  // Pull-up groups that only act in single-chip mode: ports 0-3, low nibbles of 4 and 5
  localparam logic [NUM_GROUPS-1:0] SINGLE_ONLY_GROUPS = 22'h0005FF;
  localparam logic [PORT_W-1:0] RESET_DRIVE = 8'h00;
  localparam logic [NUM_BITS-1:0] RESET_BITS = 88'h0;
  localparam logic [NUM_BITS-1:0] SYNC_IDLE = 88'hFFFFFF_FFFFFFFF_FFFFFFFF;

  typedef enum logic [1:0] {KIND_DATA, KIND_DIR, KIND_DRIVE, KIND_MODE} kind_type;
  typedef enum logic [MODE_SEL_W-1:0] {MODE_SINGLE, MODE_EXPANSION, MODE_MICRO} mode_type;

  typedef struct packed {
    logic en;
    kind_type kind;
    logic [PORT_SEL_W-1:0] port;
    logic [PORT_W-1:0] data;
  } wr_req_type;

  typedef struct packed {
    kind_type kind;
    logic [PORT_SEL_W-1:0] port;
  } rd_req_type;
endpackage

//--- rtl/pin_sync.sv
// Two-stage synchroniser for the sampled pin levels
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] IDLE = '1
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_clock_en,
  // Levels
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // Idle high so a released line does not look like a falling edge
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      meta_r <= IDLE;
      sync_r <= IDLE;
    end else if (i_clock_en) begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;
endmodule

//--- rtl/gpio_bank.sv
// Programmable I/O port bank: latches, directions, pull-ups, drive and NMI bit
`timescale 1ns/1ps
// Behaviour
// R1: Output direction drives latched value onto pin
// R2: Input direction: write updates latch, pin floats
// R3: Output bits read back the latch
// R4: Input bits read back the pin level
// R5: Shared bit: no direction, no pull-up, read-only
// R6: Falling edge on shared bit always raises NMI
// R7: One pull-up enable per four-bit group
// R8: Pull-up connects only while bit is input
// R9: Low-port pull-ups act only in single-chip mode
// R10: Bus pins' port/direction bits locked outside single-chip
// R11: Push-pull outputs; port 7 bits 0-1 open drain
// R12: Port 7 bits select normal or high sink
// R13: All bits input after reset until changed
// R14: Mode-select low keeps bus control pins as inputs
// R15: Software should rewrite directions periodically
// R16: Software keeps pull-ups off oscillator and analog pins
// R17: Per-bit direction and data registers per port
// R18: Eighty-one bidirectional bits plus one input-only bit
// R19: Direction one is output, resets to zero
// R20: Pin reads pass a two-stage synchroniser
module gpio_bank
  import gpio_bank_pkg::*;
#(
  parameter logic [NUM_BITS-1:0] BUS_PINS = BUS_PIN_MASK
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_clock_en,
  // Register access
  input wire wr_req_type i_wr,
  input wire rd_req_type i_rd,
  output logic [PORT_W-1:0] o_rd_data,
  // Configuration
  input wire logic [NUM_GROUPS-1:0] i_pull_groups,
  input wire logic i_processor_mode_select_pin,
  output mode_type o_mode,
  // Pins
  input wire logic [NUM_BITS-1:0] i_pin_in,
  output logic [NUM_BITS-1:0] o_pin_out,
  output logic [NUM_BITS-1:0] o_pin_oe,
  output logic [NUM_BITS-1:0] o_pull_up,
  output logic [PORT_W-1:0] o_high_drive,
  // Interrupt request
  output logic o_nmi_request
);
  function automatic logic [NUM_BITS-1:0] byte_mask(input logic [PORT_SEL_W-1:0] p);
    byte_mask = NUM_BITS'({PORT_W{1'b1}}) << (PORT_W * int'(p));
  endfunction

  function automatic logic [PORT_W-1:0] get_byte(input logic [NUM_BITS-1:0] v,
                                                 input logic [PORT_SEL_W-1:0] p);
    get_byte = (int'(p) < NUM_PORTS) ? v[int'(p) * PORT_W +: PORT_W] : '0;
  endfunction

  function automatic logic [NUM_BITS-1:0] expand_groups(input logic [NUM_GROUPS-1:0] g);
    for (int i = 0; i < NUM_GROUPS; i++) begin
      expand_groups[i * GROUP_W +: GROUP_W] = {GROUP_W{g[i]}};
    end
  endfunction

  logic [NUM_BITS-1:0] latch_r;
  logic [NUM_BITS-1:0] latch_nxt;
  logic [NUM_BITS-1:0] dir_r;
  logic [NUM_BITS-1:0] dir_nxt;
  logic [PORT_W-1:0] drive_r;
  mode_type mode_r;
  logic strap_taken_r;
  logic shared_prev_r;
  logic nmi_r;
  logic [PORT_W-1:0] rd_data_r;
  logic [PORT_W-1:0] rd_data_nxt;
  logic [NUM_BITS-1:0] pin_sync_lvl;

  wire port_ok = int'(i_wr.port) < NUM_PORTS;
  wire wr_data = i_wr.en && port_ok && (i_wr.kind == KIND_DATA);
  wire wr_dir = i_wr.en && port_ok && (i_wr.kind == KIND_DIR);
  wire wr_drive = i_wr.en && (i_wr.kind == KIND_DRIVE) && (i_wr.port == HIGH_SINK_PORT);
  wire wr_mode = i_wr.en && (i_wr.kind == KIND_MODE) && (i_wr.data[MODE_SEL_W-1:0] <= MODE_MICRO);
  wire single_chip = (mode_r == MODE_SINGLE);

  // Bus-owned pins ignore writes in expansion and microprocessor modes
  wire [NUM_BITS-1:0] locked = single_chip ? '0 : BUS_PINS; // [R10]
  wire [NUM_BITS-1:0] wr_bits = byte_mask(i_wr.port) & ~locked;
  wire [NUM_BITS-1:0] wr_value = {NUM_PORTS{i_wr.data}};

  // Latch takes the write whatever the direction, except on bus pins locked outside single-chip mode
  assign latch_nxt = wr_data ? ((latch_r & ~wr_bits) | (wr_value & wr_bits)) : latch_r; // [R2]
  // Shared bit and missing bits never hold a direction
  assign dir_nxt = wr_dir ? ((dir_r & ~wr_bits) | (wr_value & wr_bits & BIDIR_MASK))
                          : dir_r; // [R5] [R17] [R18] [R19]

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      latch_r <= RESET_BITS;
      dir_r <= RESET_BITS; // [R13]
      drive_r <= RESET_DRIVE;
    end else if (i_clock_en) begin
      latch_r <= latch_nxt;
      dir_r <= dir_nxt;
      if (wr_drive) begin
        drive_r <= i_wr.data; // [R12]
      end
    end
  end

  // Mode taken from the strap one cycle after release, then software owns it
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      mode_r <= MODE_SINGLE;
      strap_taken_r <= 1'b0;
    end else if (i_clock_en) begin
      if (!strap_taken_r) begin
        strap_taken_r <= 1'b1;
        mode_r <= i_processor_mode_select_pin ? MODE_MICRO : MODE_SINGLE; // [R14]
      end else if (wr_mode) begin
        mode_r <= mode_type'(i_wr.data[MODE_SEL_W-1:0]);
      end
    end
  end

  pin_sync #(
    .WIDTH(NUM_BITS),
    .IDLE(SYNC_IDLE)
  ) u_sync (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_clock_en(i_clock_en),
    .i_async(i_pin_in),
    .o_sync(pin_sync_lvl)
  ); // [R20]

  // No enable exists for this request
  wire shared_lvl = pin_sync_lvl[SHARED_IDX];
  wire shared_fall = shared_prev_r && !shared_lvl; // [R6]

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      shared_prev_r <= 1'b1;
      nmi_r <= 1'b0;
    end else if (i_clock_en) begin
      shared_prev_r <= shared_lvl;
      nmi_r <= shared_fall; // [R6]
    end
  end

  // Read-back selects latch or pin per bit direction
  wire [NUM_BITS-1:0] data_view = ((dir_r & latch_r) | (~dir_r & pin_sync_lvl))
                                  & (BIDIR_MASK | SHARED_MASK); // [R3] [R4] [R5]

  always_comb begin
    case (i_rd.kind)
      KIND_DATA: rd_data_nxt = get_byte(data_view, i_rd.port);
      KIND_DIR: rd_data_nxt = get_byte(dir_r, i_rd.port);
      KIND_DRIVE: rd_data_nxt = (i_rd.port == HIGH_SINK_PORT) ? drive_r : '0;
      KIND_MODE: rd_data_nxt = PORT_W'(mode_r);
      default: rd_data_nxt = '0;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rd_data_r <= '0;
    end else if (i_clock_en) begin
      rd_data_r <= rd_data_nxt;
    end
  end

  // Open-drain bits only ever pull low
  wire [NUM_BITS-1:0] od_bits = byte_mask(HIGH_SINK_PORT) & {NUM_PORTS{OPEN_DRAIN_MASK}};
  wire [NUM_BITS-1:0] drive_bits = dir_r & BIDIR_MASK;
  assign o_pin_out = latch_r & ~od_bits; // [R1] [R11]
  assign o_pin_oe = drive_bits & ~(od_bits & latch_r); // [R1] [R2] [R11]

  // Pull-up gated by group enable, input direction and processor mode
  wire [NUM_BITS-1:0] pull_allowed = single_chip ? '1 : ~expand_groups(SINGLE_ONLY_GROUPS);
  assign o_pull_up = expand_groups(i_pull_groups) & ~dir_r & BIDIR_MASK
                     & pull_allowed; // [R7] [R8] [R9]

  assign o_high_drive = drive_r; // [R12]
  assign o_mode = mode_r;
  assign o_rd_data = rd_data_r;
  assign o_nmi_request = nmi_r;

  // Checks
  localparam logic [PORT_SEL_W-1:0] CHK_PORT = 4'h6;
  localparam logic [PORT_SEL_W-1:0] SHARED_PORT = PORT_SEL_W'(SHARED_IDX / PORT_W);
  localparam int SHARED_POS = SHARED_IDX % PORT_W;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  sequence s_data_write;
    i_clock_en && wr_data && (i_wr.port == CHK_PORT) && !locked[CHK_PORT * PORT_W];
  endsequence

  sequence s_shared_fall;
    i_clock_en && $past(i_clock_en) && $fell(shared_lvl);
  endsequence

  property p_output_drive;
    s_data_write ##1 (get_byte(dir_r, CHK_PORT) == '1)
      |-> get_byte(o_pin_out, CHK_PORT) == $past(i_wr.data);
  endproperty
  a_output_drive: assert property (p_output_drive) else $error("output latch not driven"); // [R1]

  property p_input_float;
    get_byte(dir_r, CHK_PORT) == '0 |-> get_byte(o_pin_oe, CHK_PORT) == '0;
  endproperty
  a_input_float: assert property (p_input_float) else $error("input bit driven"); // [R2]

  property p_read_latch;
    i_clock_en && i_rd.kind == KIND_DATA && get_byte(dir_r, i_rd.port) == '1
      && int'(i_rd.port) < NUM_PORTS && i_rd.port != 4'h8
      |=> o_rd_data == get_byte($past(latch_r), $past(i_rd.port));
  endproperty
  a_read_latch: assert property (p_read_latch) else $error("output read not latch"); // [R3]

  property p_read_pin;
    i_clock_en && i_rd.kind == KIND_DATA && int'(i_rd.port) < NUM_PORTS
      && get_byte(dir_r, i_rd.port) == '0
      |=> o_rd_data == get_byte($past(pin_sync_lvl) & (BIDIR_MASK | SHARED_MASK),
                                $past(i_rd.port));
  endproperty
  a_read_pin: assert property (p_read_pin) else $error("input read not pin"); // [R4]

  property p_shared_passive;
    !o_pin_oe[SHARED_IDX] && !o_pull_up[SHARED_IDX] && !dir_r[SHARED_IDX];
  endproperty
  a_shared_passive: assert property (p_shared_passive) else $error("shared bit active"); // [R5]

  property p_nmi_edge;
    s_shared_fall |=> o_nmi_request;
  endproperty
  a_nmi_edge: assert property (p_nmi_edge) else $error("falling edge lost"); // [R6]

  property p_pull_input_only;
    (o_pull_up & o_pin_oe) == '0 && (o_pull_up & dir_r) == '0;
  endproperty
  a_pull_input_only: assert property (p_pull_input_only) else $error("pull on output"); // [R8]

  property p_pull_mode;
    !single_chip |-> (o_pull_up & expand_groups(SINGLE_ONLY_GROUPS)) == '0;
  endproperty
  a_pull_mode: assert property (p_pull_mode) else $error("pull-up outside single"); // [R9]

  property p_bus_locked;
    i_clock_en && i_wr.en && !single_chip && port_ok
      |=> ((latch_r ^ $past(latch_r)) & BUS_PINS) == '0
          && ((dir_r ^ $past(dir_r)) & BUS_PINS) == '0;
  endproperty
  a_bus_locked: assert property (p_bus_locked) else $error("bus pin register changed"); // [R10]

  property p_open_drain;
    (o_pin_out & od_bits) == '0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain driven high"); // [R11]

  property p_reset_input;
    $fell(i_reset) |-> o_pin_oe == '0 && dir_r == '0;
  endproperty
  a_reset_input: assert property (@(posedge i_clock) p_reset_input)
    else $error("bit driven after reset"); // [R13]

  property p_latch_any_dir;
    s_data_write |=> get_byte(latch_r, CHK_PORT) == $past(i_wr.data);
  endproperty
  a_latch_any_dir: assert property (p_latch_any_dir) else $error("latch write lost"); // [R2]

  property p_shared_read;
    i_clock_en && i_rd.kind == KIND_DATA && i_rd.port == SHARED_PORT
      |=> o_rd_data[SHARED_POS] == $past(pin_sync_lvl[SHARED_IDX]);
  endproperty
  a_shared_read: assert property (p_shared_read) else $error("shared bit not pin"); // [R5]

  property p_nmi_pulse;
    i_clock_en && o_nmi_request |=> !o_nmi_request;
  endproperty
  a_nmi_pulse: assert property (p_nmi_pulse) else $error("request too long"); // [R6]

  property p_drain_release;
    (o_pin_oe & od_bits) == (dir_r & od_bits & ~latch_r);
  endproperty
  a_drain_release: assert property (p_drain_release) else $error("drain not released"); // [R11]

  property p_drive_write;
    i_clock_en && wr_drive |=> o_high_drive == $past(i_wr.data);
  endproperty
  a_drive_write: assert property (p_drive_write) else $error("sink strength lost"); // [R12]

  property p_drive_hold;
    i_clock_en && !wr_drive |=> $stable(o_high_drive);
  endproperty
  a_drive_hold: assert property (p_drive_hold) else $error("sink strength changed"); // [R12]

  property p_mode_hold;
    i_clock_en && strap_taken_r && !wr_mode |=> $stable(o_mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed"); // [R14]

  property p_sync_depth;
    $past(i_clock_en) && $past(i_clock_en, 2) && !$past(i_reset) && !$past(i_reset, 2)
      |-> pin_sync_lvl == $past(i_pin_in, 2);
  endproperty
  a_sync_depth: assert property (p_sync_depth) else $error("sync depth wrong"); // [R20]
endmodule

//--- dv/pin_model.sv
// Board-side pin model: resolves device drive, external drive and pull-ups
`timescale 1ns/1ps
module pin_model
  import gpio_bank_pkg::*;
(
  // Clock
  input wire logic i_clock,
  // Device side
  input wire logic [NUM_BITS-1:0] i_pin_out,
  input wire logic [NUM_BITS-1:0] i_pin_oe,
  input wire logic [NUM_BITS-1:0] i_pull_up,
  // Board side
  input wire logic [NUM_BITS-1:0] i_ext_en,
  input wire logic [NUM_BITS-1:0] i_ext_val,
  output logic [NUM_BITS-1:0] o_level
);
  logic [NUM_BITS-1:0] last_r = '0;
  // Floating pins toggle so a stale level never reads as valid
  assign o_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_en & i_ext_val)
                 | (~i_pin_oe & ~i_ext_en & (i_pull_up | ~last_r));
  always_ff @(posedge i_clock) begin
    last_r <= o_level;
  end
endmodule

//--- dv/tb.sv
// Self-checking bench for the programmable I/O port bank
`timescale 1ns/1ps
module tb;
  import gpio_bank_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic strap = 1'b0;
  logic clock_en = 1'b1;
  wr_req_type wr_req = '0;
  rd_req_type rd_req = '0;
  logic [NUM_GROUPS-1:0] groups = 22'h3FFFFF;
  logic [NUM_BITS-1:0] ext_en = SHARED_MASK;
  logic [NUM_BITS-1:0] ext_val = SYNC_IDLE;
  logic [NUM_BITS-1:0] pin_in, pin_out, pin_oe, pull_up;
  logic [PORT_W-1:0] rd_data, high_drive, got;
  mode_type mode;
  logic nmi;
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;
  int pulses;

  gpio_bank i_dut (.i_clock(clock), .i_reset(reset), .i_clock_en(clock_en), .i_wr(wr_req),
    .i_rd(rd_req), .o_rd_data(rd_data), .i_pull_groups(groups),
    .i_processor_mode_select_pin(strap), .o_mode(mode), .i_pin_in(pin_in),
    .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_pull_up(pull_up),
    .o_high_drive(high_drive), .o_nmi_request(nmi));
  pin_model i_pins (.i_clock(clock), .i_pin_out(pin_out), .i_pin_oe(pin_oe),
    .i_pull_up(pull_up), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(pin_in));

  initial begin
    forever #2.5 clock = ~clock;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles > 3000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input string name, input logic [NUM_BITS-1:0] exp, got_v);
    cmp_count++;
    if (got_v !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got_v);
    end
  endtask
  task automatic wr(input kind_type k, input logic [3:0] p, input logic [7:0] d);
    wr_req = '{en: 1'b1, kind: k, port: p, data: d};
    tick();
    wr_req.en = 1'b0;
    // One idle edge so back-to-back calls never retouch the request in one step
    tick();
  endtask
  task automatic rd(input kind_type k, input logic [3:0] p);
    rd_req = '{kind: k, port: p};
    tick();
    got = rd_data;
  endtask
  task automatic do_reset(input logic s);
    reset = 1'b1;
    strap = s;
    tick(5);
    reset = 1'b0;
    tick();
  endtask

  task automatic t_reset();
    chk("oe", '0, pin_oe);
    chk("pull", BIDIR_MASK, pull_up);
    chk("hdrive", '0, high_drive);
    chk("mode", MODE_SINGLE, mode);
    chk("nmi", '0, nmi);
  endtask
  task automatic t_output();
    ext_en[55:48] = 8'hFF;
    ext_val[55:48] = 8'h5A;
    wr(KIND_DIR, 4'h6, 8'hFF);
    chk("oe6", 8'hFF, pin_oe[55:48]);
    chk("pull6", 8'h00, pull_up[55:48]);
    wr(KIND_DATA, 4'h6, 8'hA5);
    chk("out6", 8'hA5, pin_out[55:48]);
    tick(3);
    rd(KIND_DATA, 4'h6);
    chk("rd6", 8'hA5, got);
    ext_en[55:48] = 8'h00;
  endtask
  task automatic t_input();
    ext_en[79:72] = 8'hFF;
    ext_val[79:72] = 8'hF5;
    wr(KIND_DATA, 4'h9, 8'h0A);
    chk("oe9", 8'h00, pin_oe[79:72]);
    chk("lat9", 8'h0A, pin_out[79:72]);
    tick(3);
    rd(KIND_DATA, 4'h9);
    chk("rd9", 8'h15, got);
    rd(KIND_DATA, 4'hB);
    chk("rdbad", 8'h00, got);
  endtask
  task automatic t_drain();
    wr(KIND_DIR, 4'h7, 8'hFF);
    wr(KIND_DATA, 4'h7, 8'h00);
    chk("oe7lo", 8'hFF, pin_oe[63:56]);
    wr(KIND_DATA, 4'h7, 8'hFF);
    chk("oe7hi", 8'hFC, pin_oe[63:56]);
    chk("out7", 8'hFC, pin_out[63:56]);
    wr(KIND_DRIVE, 4'h7, 8'h5A);
    chk("hd", 8'h5A, high_drive);
    wr(KIND_DRIVE, 4'h6, 8'hFF);
    chk("hd6", 8'h5A, high_drive);
    rd(KIND_DRIVE, 4'h7);
    tick();
    chk("rdhd", 8'h5A, rd_data);
  endtask
  task automatic t_shared();
    // Single all-ones direction write to port 8, which the shared bit must ignore
    wr(KIND_DIR, 4'h8, 8'hFF);
    chk("oe69", 1'b0, pin_oe[SHARED_IDX]);
    chk("pu69", 1'b0, pull_up[SHARED_IDX]);
    ext_val[SHARED_IDX] = 1'b0;
    pulses = 0;
    repeat (8) begin
      tick();
      pulses += int'(nmi === 1'b1);
    end
    chk("nmi", 1, pulses);
    rd(KIND_DATA, 4'h8);
    chk("rd69", 1'b0, got[5]);
    ext_val[SHARED_IDX] = 1'b1;
    tick(4);
  endtask
  task automatic t_group();
    groups[18] = 1'b0;
    tick();
    chk("grp18", 8'h10, pull_up[79:72]);
    chk("grp20", 8'h1F, pull_up[87:80]);
    groups[18] = 1'b1;
  endtask
  task automatic t_freeze();
    // Enable low: the write must not land
    clock_en = 1'b0;
    wr(KIND_DATA, 4'h6, 8'h3C);
    clock_en = 1'b1;
    chk("frz6", 8'hA5, pin_out[55:48]);
  endtask
  task automatic t_mode();
    // Pull-ups stay off oscillator and analog pins in this stimulus
    wr(KIND_MODE, 4'h0, 8'h01);
    chk("mode", MODE_EXPANSION, mode);
    wr(KIND_DIR, 4'h0, 8'hFF);
    chk("oe0", 8'h00, pin_oe[7:0]);
    wr(KIND_DATA, 4'h0, 8'h3C);
    chk("lat0", 8'h00, pin_out[7:0]);
    chk("pu03", 36'h0, pull_up[35:0]);
    chk("pu45", 8'h0F, pull_up[43:36]);
    wr(KIND_MODE, 4'h0, 8'h00);
    wr(KIND_MODE, 4'h0, 8'h03);
    chk("mode3", MODE_SINGLE, mode);
    wr(KIND_DIR, 4'h0, 8'hFF);
    chk("oe0s", 8'hFF, pin_oe[7:0]);
  endtask
  task automatic t_strap();
    do_reset(1'b1);
    chk("micro", MODE_MICRO, mode);
    chk("oe", '0, pin_oe);
    do_reset(1'b0);
    chk("single", MODE_SINGLE, mode);
  endtask

  initial begin
    do_reset(1'b0);
    t_reset();
    t_output();
    t_input();
    t_drain();
    t_shared();
    t_group();
    t_freeze();
    t_mode();
    t_strap();
    finish_test();
  end
endmodule
